/* File: shared/isp_params.svh */
// constants for the two-wire register pointer slave and its host end
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

`define ISP_DEV_ADDR      7'h36
`define ISP_BIT_ACK       4'h8
`define ISP_BIT_END       4'h9
`define ISP_PTR_RST       8'h00
`define ISP_PTR_STEP      8'h01
`define ISP_SPIKE_NS      50
`define ISP_LINK_NS       30
`define ISP_FILT_CYC      ((`ISP_SPIKE_NS + `ISP_LINK_NS - 1) / `ISP_LINK_NS)
`define ISP_SYS_NS        10
`define ISP_QTR_NS        300
`define ISP_QTR_CYC       ((`ISP_QTR_NS + `ISP_SYS_NS - 1) / `ISP_SYS_NS)
`define ISP_RD_VALID_DEF  256'h1C00FF87
`define ISP_WR_VALID_DEF  {1'b1, 255'h0786}
`define ISP_NOINC_A_DEF   8'h0C
`define ISP_NOINC_B_DEF   8'h0E
`define ISP_NOINC_C_DEF   8'h1B

`endif

/* File: shared/isp_pkg.sv */
// types for the two ends of the two-wire link: device states, host states and host command codes
package isp_pkg;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_DEVADDR = 3'h1,
		ST_WORD    = 3'h2,
		ST_WDATA   = 3'h3,
		ST_RDATA   = 3'h4,
		ST_SKIP    = 3'h5
	} isp_dstate_t;

	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BITS  = 2'h2,
		M_STOP  = 2'h3
	} isp_mstate_t;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ  = 2'h3
	} isp_op_t;

endpackage : isp_pkg

/* File: shared/isp_if.sv */
// open-drain two-wire link joining host and device ends
`timescale 1ns/1ps
interface isp_if;
	logic scl_o_host;
	logic scl_oe_host;
	logic sda_o_host;
	logic sda_oe_host;
	logic sda_o_dev;
	logic sda_oe_dev;
	logic scl;
	logic sda;

	// wired-and with pull-up
	assign scl = (scl_oe_host && !scl_o_host) ? 1'b0 : 1'b1;
	assign sda = ((sda_oe_host && !sda_o_host) ||
		(sda_oe_dev && !sda_o_dev)) ? 1'b0 : 1'b1;

	modport host (
		output scl_o_host,
		output scl_oe_host,
		output sda_o_host,
		output sda_oe_host,
		input  scl,
		input  sda
	);

	modport dev (
		output sda_o_dev,
		output sda_oe_dev,
		input  scl,
		input  sda
	);
endinterface : isp_if

/* File: design/isp_master.sv */
// host end: bus master driving the link clock from clk_sys
`timescale 1ns/1ps
`include "isp_params.svh"
module isp_master
	import isp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	isp_if.host             bus,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire isp_op_t    cmd_op,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_nack,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack
);
	isp_mstate_t mst;
	logic [1:0]  meta;
	logic [1:0]  sync;
	logic [5:0]  qcnt;
	logic        tick;
	logic [1:0]  phase;
	logic [3:0]  bitn;
	logic [8:0]  tx;
	logic [8:0]  rx;
	logic        scl_oe;
	logic        sda_oe;

	assign bus.scl_o_host  = 1'b0;
	assign bus.sda_o_host  = 1'b0;
	assign bus.scl_oe_host = scl_oe;
	assign bus.sda_oe_host = sda_oe;
	assign tick = (qcnt == 6'(`ISP_QTR_CYC - 1));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 2'h3;
			sync <= 2'h3;
		end else begin
			meta <= {bus.scl, bus.sda};
			sync <= meta;
		end
	end

	// quarter bit timer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			qcnt <= 6'h00;
		end else if (mst == M_IDLE || tick) begin
			qcnt <= 6'h00;
		end else begin
			qcnt <= qcnt + 6'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mst       <= M_IDLE;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			rsp_nack  <= 1'b0;
			phase     <= 2'h0;
			bitn      <= 4'h0;
			tx        <= 9'h1FF;
			rx        <= 9'h000;
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (mst)
			M_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					phase     <= 2'h0;
					bitn      <= 4'h0;
					case (cmd_op)
					OP_START: mst <= M_START;
					OP_STOP:  mst <= M_STOP;
					OP_WRITE: begin
						tx  <= {cmd_data, 1'b1};
						mst <= M_BITS;
					end
					default: begin
						tx  <= {8'hFF, cmd_nack};
						mst <= M_BITS;
					end
					endcase
				end
			end
			M_START: if (tick) begin
				case (phase)
				2'h0: if (scl_oe || (sync[1] && sync[0])) begin
					sda_oe <= 1'b0;
					phase  <= 2'h1;
				end
				2'h1: begin
					scl_oe <= 1'b0;
					phase  <= 2'h2;
				end
				2'h2: begin
					sda_oe <= 1'b1;
					phase  <= 2'h3;
				end
				default: begin
					scl_oe    <= 1'b1;
					mst       <= M_IDLE;
					cmd_ready <= 1'b1;
				end
				endcase
			end
			M_BITS: if (tick) begin
				case (phase)
				2'h0: begin
					sda_oe <= ~tx[8];
					phase  <= 2'h1;
				end
				2'h1: begin
					scl_oe <= 1'b0;
					phase  <= 2'h2;
				end
				2'h2: begin
					rx    <= {rx[7:0], sync[0]};
					phase <= 2'h3;
				end
				default: begin
					scl_oe <= 1'b1;
					tx     <= {tx[7:0], 1'b1};
					phase  <= 2'h0;
					if (bitn == `ISP_BIT_ACK) begin
						mst       <= M_IDLE;
						cmd_ready <= 1'b1;
						rsp_valid <= 1'b1;
						rsp_data  <= rx[8:1];
						rsp_nack  <= rx[0];
					end else begin
						bitn <= bitn + 4'h1;
					end
				end
				endcase
			end
			default: if (tick) begin
				case (phase)
				2'h0: begin
					sda_oe <= 1'b1;
					phase  <= 2'h1;
				end
				2'h1: begin
					scl_oe <= 1'b0;
					phase  <= 2'h2;
				end
				2'h2: begin
					sda_oe <= 1'b0;
					phase  <= 2'h3;
				end
				default: begin
					mst       <= M_IDLE;
					cmd_ready <= 1'b1;
				end
				endcase
			end
			endcase
		end
	end
endmodule : isp_master

/* File: design/isp_slave.sv */
// device end: two-wire slave with register address pointer
`timescale 1ns/1ps
`include "isp_params.svh"
module isp_slave
	import isp_pkg::*;
#(
	parameter logic [255:0] RD_VALID = `ISP_RD_VALID_DEF,
	parameter logic [255:0] WR_VALID = `ISP_WR_VALID_DEF,
	parameter logic [7:0]   NOINC_A  = `ISP_NOINC_A_DEF,
	parameter logic [7:0]   NOINC_B  = `ISP_NOINC_B_DEF,
	parameter logic [7:0]   NOINC_C  = `ISP_NOINC_C_DEF
)(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       clk_link,
	isp_if.dev              bus,
	output logic [7:0]      reg_rd_addr,
	input  wire logic [7:0] reg_rd_data,
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_addr,
	output logic [7:0]      reg_wr_data
);
	isp_dstate_t st;
	logic [1:0]  in_raw;
	logic [1:0]  filt;
	logic [1:0]  filt_q;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  tx;
	logic [7:0]  ptr;
	logic        rw;
	logic        mack;
	logic        sda_oe;
	logic        noinc;
	logic [7:0]  byte_out;
	logic [7:0]  fetch_addr;
	logic        fetch_tgl;
	logic [7:0]  fetch_data;
	logic [2:0]  ack_sync;
	logic [7:0]  wr_addr_l;
	logic [7:0]  wr_data_l;
	logic        wr_tgl;
	logic [2:0]  f_sync;
	logic [2:0]  w_sync;
	logic        pend;
	logic [7:0]  rd_hold;
	logic        ack_tgl;

	assign bus.sda_o_dev  = 1'b0;
	assign bus.sda_oe_dev = sda_oe;
	assign in_raw = {bus.scl, bus.sda};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			logic       meta;
			logic       sync;
			logic       lvl;
			logic [1:0] cnt;
			always_ff @(posedge clk_link or negedge rst_b) begin
				if (!rst_b) begin
					meta <= 1'b1;
					sync <= 1'b1;
				end else begin
					meta <= in_raw[gi];
					sync <= meta;
				end
			end
			always_ff @(posedge clk_link or negedge rst_b) begin
				if (!rst_b) begin
					lvl <= 1'b1;
					cnt <= 2'h0;
				end else if (sync == lvl) begin
					cnt <= 2'h0;
				end else if (cnt == 2'(`ISP_FILT_CYC - 1)) begin
					lvl <= sync;
					cnt <= 2'h0;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
			assign filt[gi] = lvl;
		end
	endgenerate

	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			filt_q <= 2'h3;
		end else begin
			filt_q <= filt;
		end
	end

	assign rise = filt[1] & ~filt_q[1];
	assign fall = ~filt[1] & filt_q[1];
	assign start = filt[1] & filt_q[1] & filt_q[0] & ~filt[0];
	assign stop = filt[1] & filt_q[1] & ~filt_q[0] & filt[0];
	assign noinc = (ptr == NOINC_A) || (ptr == NOINC_B) || (ptr == NOINC_C);
	assign byte_out = RD_VALID[ptr] ? fetch_data : 8'h00;

	// bus protocol engine on the link clock
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			st         <= ST_IDLE;
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			tx         <= 8'h00;
			ptr        <= `ISP_PTR_RST;
			rw         <= 1'b0;
			mack       <= 1'b0;
			sda_oe     <= 1'b0;
			fetch_addr <= `ISP_PTR_RST;
			fetch_tgl  <= 1'b0;
			wr_addr_l  <= 8'h00;
			wr_data_l  <= 8'h00;
			wr_tgl     <= 1'b0;
		end else if (start) begin
			st     <= ST_DEVADDR;
			bitcnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop) begin
			st     <= ST_IDLE;
			sda_oe <= 1'b0;
		end else if (st != ST_IDLE && rise) begin
			if (bitcnt < `ISP_BIT_ACK) begin
				shreg  <= {shreg[6:0], filt[0]};
				bitcnt <= bitcnt + 4'h1;
			end else if (bitcnt == `ISP_BIT_ACK) begin
				mack   <= ~filt[0];
				bitcnt <= `ISP_BIT_END;
			end
		end else if (st != ST_IDLE && fall) begin
			if (bitcnt == `ISP_BIT_ACK) begin
				case (st)
				ST_DEVADDR: begin
					sda_oe     <= (shreg[7:1] == `ISP_DEV_ADDR);
					rw         <= shreg[0];
					fetch_addr <= ptr;
					fetch_tgl  <= ~fetch_tgl;
					if (shreg[7:1] != `ISP_DEV_ADDR) begin
						st <= ST_SKIP;
					end
				end
				ST_WORD: begin
					ptr        <= shreg;
					sda_oe     <= RD_VALID[shreg];
					fetch_addr <= shreg;
					fetch_tgl  <= ~fetch_tgl;
				end
				ST_WDATA: begin
					sda_oe <= WR_VALID[ptr];
					if (WR_VALID[ptr]) begin
						wr_addr_l <= ptr;
						wr_data_l <= shreg;
						wr_tgl    <= ~wr_tgl;
					end
					ptr <= ptr + `ISP_PTR_STEP;
				end
				ST_RDATA: begin
					sda_oe <= 1'b0;
					if (!noinc) begin
						ptr        <= ptr + `ISP_PTR_STEP;
						fetch_addr <= ptr + `ISP_PTR_STEP;
						fetch_tgl  <= ~fetch_tgl;
					end
				end
				default: sda_oe <= 1'b0;
				endcase
			end else if (bitcnt == `ISP_BIT_END) begin
				bitcnt <= 4'h0;
				case (st)
				ST_DEVADDR: begin
					if (rw) begin
						st     <= ST_RDATA;
						tx     <= byte_out;
						sda_oe <= ~byte_out[7];
					end else begin
						st     <= ST_WORD;
						sda_oe <= 1'b0;
					end
				end
				ST_WORD: begin
					st     <= ST_WDATA;
					sda_oe <= 1'b0;
				end
				ST_RDATA: begin
					if (mack) begin
						tx     <= byte_out;
						sda_oe <= ~byte_out[7];
					end else begin
						st     <= ST_SKIP;
						sda_oe <= 1'b0;
					end
				end
				default: sda_oe <= 1'b0;
				endcase
			end else if (st == ST_RDATA) begin
				tx     <= {tx[6:0], 1'b0};
				sda_oe <= ~tx[6];
			end
		end
	end

	// read fetch result back into link domain
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			ack_sync   <= 3'h0;
			fetch_data <= 8'h00;
		end else begin
			ack_sync <= {ack_sync[1:0], ack_tgl};
			if (ack_sync[2] ^ ack_sync[1]) begin
				fetch_data <= rd_hold;
			end
		end
	end

	// system side of read handshake
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			f_sync      <= 3'h0;
			pend        <= 1'b0;
			reg_rd_addr <= `ISP_PTR_RST;
			rd_hold     <= 8'h00;
			ack_tgl     <= 1'b0;
		end else begin
			f_sync <= {f_sync[1:0], fetch_tgl};
			pend   <= f_sync[2] ^ f_sync[1];
			if (f_sync[2] ^ f_sync[1]) begin
				reg_rd_addr <= fetch_addr;
			end
			if (pend) begin
				rd_hold <= reg_rd_data;
				ack_tgl <= ~ack_tgl;
			end
		end
	end

	// system side write strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			w_sync      <= 3'h0;
			reg_wr_en   <= 1'b0;
			reg_wr_addr <= 8'h00;
			reg_wr_data <= 8'h00;
		end else begin
			w_sync    <= {w_sync[1:0], wr_tgl};
			reg_wr_en <= w_sync[2] ^ w_sync[1];
			if (w_sync[2] ^ w_sync[1]) begin
				reg_wr_addr <= wr_addr_l;
				reg_wr_data <= wr_data_l;
			end
		end
	end
endmodule : isp_slave

/* File: sim/isp_link_properties.sv */
// bus-level checks on the shared two-wire link
`timescale 1ns/1ps
module isp_link_properties (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic scl_oe_host,
	input  wire logic sda_oe_host,
	input  wire logic sda_oe_dev,
	input  wire logic scl,
	input  wire logic sda
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	chk_dev_stable_high: assert property (
		scl && $past(scl) |-> $stable(sda_oe_dev))
		else $error("device data moved while clock high");
	chk_start_by_host: assert property (
		$fell(sda) && scl && $past(scl) |-> sda_oe_host && !sda_oe_dev)
		else $error("start not made by host alone");
	chk_stop_released: assert property (
		$rose(sda) && scl && $past(scl)
		|-> $past(sda_oe_host) && !$past(sda_oe_dev))
		else $error("stop with device still driving");
	chk_scl_host_only: assert property (
		!scl |-> scl_oe_host)
		else $error("clock low without host pulling");
	chk_dev_low_held: assert property (
		$rose(scl) && sda_oe_dev |-> (sda_oe_dev && !sda) until !scl)
		else $error("device low not held over high phase");
	chk_scl_high_min: assert property (
		$rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	chk_reset_lines: assert property (
		$rose(rst_b) |-> !scl_oe_host && !sda_oe_host && !sda_oe_dev)
		else $error("bus not idle after reset");
	chk_start_setup: assert property (
		$fell(sda) && scl |-> $past(scl, 26))
		else $error("start without clock high setup");

	cov_start: cover property ($fell(sda) && scl);
	cov_dev_low: cover property ($rose(scl) && sda_oe_dev);
	cov_stop: cover property ($rose(sda) && scl);
endmodule : isp_link_properties

/* File: sim/test_i2c_slave_register_pointer.sv */
// bench joining host and device ends over the shared bus
`timescale 1ns/1ps
`include "isp_params.svh"
module test_i2c_slave_register_pointer
	import isp_pkg::*;
;
	localparam logic [255:0] RDV = `ISP_RD_VALID_DEF;
	localparam logic [255:0] WRV = `ISP_WR_VALID_DEF;
	logic       clk_sys = 1'b0;
	logic       clk_link = 1'b0;
	logic       rst_b = 1'b0;
	logic       cmd_valid = 1'b0;
	logic       cmd_ready;
	isp_op_t    cmd_op = OP_STOP;
	logic [7:0] cmd_data = 8'h00;
	logic       cmd_nack = 1'b0;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_nack;
	logic [7:0] reg_rd_addr;
	logic [7:0] reg_rd_data;
	logic       reg_wr_en;
	logic [7:0] reg_wr_addr;
	logic [7:0] reg_wr_data;
	logic [7:0] regs [256];
	logic [7:0] exp_mem [256];
	logic [7:0] ptr = 8'h00;
	logic [7:0] wr_seen = 8'h00;
	logic [7:0] wr_want = 8'h00;
	int         seed = 32'hE271E54A;
	int         bad_count = 0;
	int         checks_done = 0;
	int         cycles = 0;

	isp_if bus ();

	isp_master u_isp_master (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.bus       (bus),
		.cmd_valid (cmd_valid),
		.cmd_ready (cmd_ready),
		.cmd_op    (cmd_op),
		.cmd_data  (cmd_data),
		.cmd_nack  (cmd_nack),
		.rsp_valid (rsp_valid),
		.rsp_data  (rsp_data),
		.rsp_nack  (rsp_nack)
	);

	isp_slave u_isp_slave (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.clk_link    (clk_link),
		.bus         (bus),
		.reg_rd_addr (reg_rd_addr),
		.reg_rd_data (reg_rd_data),
		.reg_wr_en   (reg_wr_en),
		.reg_wr_addr (reg_wr_addr),
		.reg_wr_data (reg_wr_data)
	);

	isp_link_properties u_isp_link_properties (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.scl_oe_host (bus.scl_oe_host),
		.sda_oe_host (bus.sda_oe_host),
		.sda_oe_dev  (bus.sda_oe_dev),
		.scl         (bus.scl),
		.sda         (bus.sda)
	);

	always #5 clk_sys = ~clk_sys;
	initial begin
		#3.3;
		forever #15 clk_link = ~clk_link;
	end

	// register map stand-in
	assign reg_rd_data = regs[reg_rd_addr];
	always @(posedge clk_sys) begin
		if (reg_wr_en === 1'b1) begin
			regs[reg_wr_addr] <= reg_wr_data;
			wr_seen <= wr_seen + 8'h01;
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			results();
		end
	end

	task check(input string name, input logic [7:0] seen,
		input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask : check

	task results();
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	function automatic logic [7:0] want(input logic [7:0] p);
		return RDV[p] ? exp_mem[p] : 8'h00;
	endfunction : want

	function automatic logic stay(input logic [7:0] p);
		return p == `ISP_NOINC_A_DEF || p == `ISP_NOINC_B_DEF ||
			p == `ISP_NOINC_C_DEF;
	endfunction : stay

	task op(input isp_op_t o, input logic [7:0] d, input logic n);
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		cmd_nack = n;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		do begin
			@(posedge clk_sys);
			#1;
		end while (cmd_ready !== 1'b1);
		if (o[1]) check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
	endtask : op

	task addr(input logic rw);
		op(OP_START, 8'h00, 1'b0);
		op(OP_WRITE, {`ISP_DEV_ADDR, rw}, 1'b0);
		check("address ack", {7'h00, rsp_nack}, 8'h00);
	endtask : addr

	task wr(input logic [7:0] a, input int n);
		logic [7:0] d;
		addr(1'b0);
		op(OP_WRITE, a, 1'b0);
		check("word ack", {7'h00, rsp_nack}, {7'h00, !RDV[a]});
		ptr = a;
		repeat (n) begin
			d = 8'($random(seed));
			op(OP_WRITE, d, 1'b0);
			check("data ack", {7'h00, rsp_nack}, {7'h00, !WRV[ptr]});
			if (WRV[ptr]) begin
				exp_mem[ptr] = d;
				wr_want = wr_want + 8'h01;
			end
			ptr = ptr + 8'h01;
		end
		op(OP_STOP, 8'h00, 1'b0);
	endtask : wr

	task rd(input logic [7:0] a, input logic set, input int n);
		if (set) begin
			addr(1'b0);
			op(OP_WRITE, a, 1'b0);
			ptr = a;
		end
		addr(1'b1);
		for (int i = 1; i <= n; i++) begin
			op(OP_READ, 8'h00, i == n);
			check("read data", rsp_data, want(ptr));
			if (!stay(ptr))
				ptr = ptr + 8'h01;
		end
		op(OP_STOP, 8'h00, 1'b0);
	endtask : rd

	initial begin
		logic [7:0] a;
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'($random(seed));
			exp_mem[i] = regs[i];
		end
		repeat (3) @(posedge clk_link);
		#1;
		rst_b = 1'b1;
		op(OP_START, 8'h00, 1'b0);
		op(OP_WRITE, {7'h37, 1'b0}, 1'b0);
		check("foreign address", {7'h00, rsp_nack}, 8'h01);
		op(OP_STOP, 8'h00, 1'b0);
		wr(8'h07, 4);
		rd(8'h00, 1'b0, 3);
		wr(8'h05, 3);
		rd(8'h07, 1'b1, 4);
		wr(8'hFE, 4);
		rd(8'hFF, 1'b1, 2);
		rd(8'h19, 1'b1, 2);
		rd(8'h0E, 1'b1, 2);
		rd(8'h1B, 1'b1, 2);
		repeat (3) begin
			a = 8'($random(seed)) & 8'h1F;
			if ($random(seed) & 1)
				wr(a, 1 + ($random(seed) & 1));
			else
				rd(a, 1'b1, 2);
		end
		repeat (10) @(posedge clk_sys);
		check("write strobes", wr_seen, wr_want);
		results();
	end
endmodule : test_i2c_slave_register_pointer
